/* inc/fcd_defines.svh */
// Named constants of the flash command driver: command codes, addresses, timing.
// Assumes a 50 MHz controller clock and a 16-bit flash data bus.
`ifndef FCD_DEFINES_SVH
`define FCD_DEFINES_SVH

// Address layout.
`define FCD_BANK_MSB 21
`define FCD_BANK_LSB 19
`define FCD_SECT_LSB 12

// Unlock and command addresses, word and byte mode.
`define FCD_A_555 19'h00555
`define FCD_A_2AA 19'h002aa
`define FCD_A_AAA 19'h00aaa
`define FCD_A_CFIW 19'h00055
`define FCD_A_CFIB 19'h000aa

// Command data codes, low byte only.
`define FCD_D_UNL1 8'haa
`define FCD_D_UNL2 8'h55
`define FCD_D_RESET 8'hf0
`define FCD_D_ASEL 8'h90
`define FCD_D_SECIN 8'h88
`define FCD_D_ZERO 8'h00
`define FCD_D_PROG 8'ha0
`define FCD_D_BYP 8'h20
`define FCD_D_ESET 8'h80
`define FCD_D_CHIP 8'h10
`define FCD_D_SECT 8'h30
`define FCD_D_SUSP 8'hb0
`define FCD_D_CFI 8'h98

// Autoselect offsets inside a bank, word then byte.
`define FCD_OW_MFR 8'h00
`define FCD_OB_MFR 8'h00
`define FCD_OW_DEV1 8'h01
`define FCD_OB_DEV1 8'h02
`define FCD_OW_DEV2 8'h0e
`define FCD_OB_DEV2 8'h1c
`define FCD_OW_DEV3 8'h0f
`define FCD_OB_DEV3 8'h1e
`define FCD_OW_LOCK 8'h03
`define FCD_OB_LOCK 8'h06
`define FCD_OW_PROT 8'h02
`define FCD_OB_PROT 8'h04

// Timing in ns and derived cycle counts; least times round up.
`define FCD_CLK_NS 20
`define FCD_TWP_NS 35
`define FCD_TWPH_NS 30
`define FCD_TACC_NS 70
`define FCD_TRP_NS 500
`define FCD_CEIL(ns) (((ns) + `FCD_CLK_NS - 1) / `FCD_CLK_NS)
`define FCD_TWP_CYC `FCD_CEIL(`FCD_TWP_NS)
`define FCD_TWPH_CYC `FCD_CEIL(`FCD_TWPH_NS)
`define FCD_TACC_CYC `FCD_CEIL(`FCD_TACC_NS)
`define FCD_TRP_CYC `FCD_CEIL(`FCD_TRP_NS)
`define FCD_SYNC_CYC 2

`endif

/* inc/fcd_pkg.sv */
// Types of the flash command driver.
// Assumes fcd_defines.svh for all numeric constants.
package fcd_pkg;

    typedef enum logic [4:0] {
        CMD_READ = 5'h00, CMD_RESET = 5'h01, CMD_AS_ENTER = 5'h02, CMD_AS_READ = 5'h03,
        CMD_SEC_ENTER = 5'h04, CMD_SEC_EXIT = 5'h05, CMD_PROG = 5'h06, CMD_BYP_ENTER = 5'h07,
        CMD_BYP_PROG = 5'h08, CMD_BYP_EXIT = 5'h09, CMD_CHIP_ERASE = 5'h0a, CMD_SECT_ERASE = 5'h0b,
        CMD_SUSPEND = 5'h0c, CMD_RESUME = 5'h0d, CMD_CFI = 5'h0e, CMD_HW_RESET = 5'h0f,
        CMD_ERASE_DONE = 5'h10
    } fcd_cmd_t;

    typedef enum logic [2:0] {
        AS_MFR = 3'b000, AS_DEV1 = 3'b001, AS_DEV2 = 3'b010, AS_DEV3 = 3'b011,
        AS_LOCK = 3'b100, AS_PROT = 3'b101
    } fcd_as_t;

    typedef enum logic [2:0] {
        MD_READ = 3'b000, MD_AUTOSEL = 3'b001, MD_BYPASS = 3'b010, MD_ERASING = 3'b011,
        MD_SUSPENDED = 3'b100, MD_CFI = 3'b101, MD_SECURE = 3'b110
    } fcd_mode_t;

    typedef enum logic [2:0] {
        PH_IDLE = 3'b000, PH_START = 3'b001, PH_SETUP = 3'b010, PH_STROBE = 3'b011,
        PH_HOLD = 3'b100, PH_RECOV = 3'b101, PH_RDWAIT = 3'b110, PH_RSTP = 3'b111
    } fcd_phase_t;

    typedef struct packed {
        fcd_cmd_t cmd;
        fcd_as_t sel;
        logic [21:0] addr;
        logic [15:0] data;
    } fcd_req_t;

    typedef struct packed {
        logic rd;
        logic last;
        logic [21:0] addr;
        logic [15:0] data;
    } fcd_cyc_t;

    typedef struct packed {
        logic ce_n;
        logic we_n;
        logic oe_n;
        logic rst_n;
        logic dq_oe_n;
        logic [21:0] addr;
        logic [15:0] dq;
    } fcd_pins_t;

    typedef struct packed {
        fcd_phase_t phase;
        fcd_mode_t mode;
        logic [2:0] bank;
        logic sect;
        logic susp;
        logic [2:0] step;
        logic byte_m;
        fcd_req_t req;
        logic [4:0] cnt;
        fcd_pins_t pins;
        logic [15:0] rdata;
        logic done;
        logic refused;
    } fcd_state_t;

endpackage : fcd_pkg

/* design/fcd_sync.sv */
// Two-stage synchroniser for a bus of pin inputs.
// Assumes the bus is only sampled once stable, as flash read data is.
`timescale 1ns/1ps
module fcd_sync #(
    parameter int W = 16
) (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_nrst,
    // Data.
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } fcd_sync_st_t;

    fcd_sync_st_t s_r, s_nxt;

    // The first stage feeds only the second stage.
    always_comb begin
        s_nxt.s1 = i_d;
        s_nxt.s2 = s_r.s1;
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_q = s_r.s2;
endmodule : fcd_sync

/* design/fcd_seq_rom.sv */
// Command sequence table: address, data and kind of each bus cycle.
// Assumes the caller steps i_step from zero until o_cyc.last.
`include "fcd_defines.svh"
`timescale 1ns/1ps
module fcd_seq_rom
    import fcd_pkg::*;
(
    // Request and position.
    input wire fcd_req_t i_req,
    input wire logic i_byte,
    input wire logic [2:0] i_step,
    // Cycle description.
    output fcd_cyc_t o_cyc
);
    logic [18:0] ua1, ua2;
    logic [2:0] bk;
    logic [7:0] off;
    logic [7:0] code3;

    // Pure lookup; upper data byte is zero on command cycles.
    always_comb begin
        ua1 = i_byte ? `FCD_A_AAA : `FCD_A_555;
        ua2 = i_byte ? `FCD_A_555 : `FCD_A_2AA;
        bk = i_req.addr[`FCD_BANK_MSB:`FCD_BANK_LSB];
        off = `FCD_OW_MFR;
        code3 = `FCD_D_ESET;
        o_cyc = '0;
        case (i_req.sel)
            AS_MFR: off = i_byte ? `FCD_OB_MFR : `FCD_OW_MFR;
            AS_DEV1: off = i_byte ? `FCD_OB_DEV1 : `FCD_OW_DEV1;
            AS_DEV2: off = i_byte ? `FCD_OB_DEV2 : `FCD_OW_DEV2;
            AS_DEV3: off = i_byte ? `FCD_OB_DEV3 : `FCD_OW_DEV3;
            AS_LOCK: off = i_byte ? `FCD_OB_LOCK : `FCD_OW_LOCK;
            default: off = i_byte ? `FCD_OB_PROT : `FCD_OW_PROT;
        endcase
        case (i_req.cmd)
            CMD_AS_ENTER, CMD_SEC_EXIT: code3 = `FCD_D_ASEL;
            CMD_SEC_ENTER: code3 = `FCD_D_SECIN;
            CMD_PROG: code3 = `FCD_D_PROG;
            CMD_BYP_ENTER: code3 = `FCD_D_BYP;
            default: code3 = `FCD_D_ESET;
        endcase
        case (i_req.cmd)
            CMD_READ: o_cyc = '{rd: 1'b1, last: 1'b1, addr: i_req.addr, data: 16'h0000};
            CMD_RESET: o_cyc = '{1'b0, 1'b1, 22'h000000, {8'h00, `FCD_D_RESET}};
            CMD_AS_READ: begin
                o_cyc.rd = 1'b1;
                o_cyc.last = 1'b1;
                o_cyc.addr = {bk, 19'(off)};
                if (i_req.sel == AS_PROT) begin
                    o_cyc.addr = {i_req.addr[21:`FCD_SECT_LSB], 12'(off)};
                end
            end
            CMD_BYP_PROG: begin
                o_cyc.last = (i_step != 3'h0);
                o_cyc.data = o_cyc.last ? i_req.data : {8'h00, `FCD_D_PROG};
                o_cyc.addr = o_cyc.last ? i_req.addr : 22'h000000;
            end
            CMD_BYP_EXIT: begin
                o_cyc.last = (i_step != 3'h0);
                o_cyc.data = {8'h00, o_cyc.last ? `FCD_D_ZERO : `FCD_D_ASEL};
            end
            CMD_SUSPEND: o_cyc = '{1'b0, 1'b1, {bk, 19'h00000}, {8'h00, `FCD_D_SUSP}};
            CMD_RESUME: o_cyc = '{1'b0, 1'b1, {bk, 19'h00000}, {8'h00, `FCD_D_SECT}};
            CMD_CFI: o_cyc = '{1'b0, 1'b1, {3'h0, i_byte ? `FCD_A_CFIB : `FCD_A_CFIW},
                {8'h00, `FCD_D_CFI}};
            CMD_HW_RESET, CMD_ERASE_DONE: o_cyc = '0;
            default: begin
                // Unlocked sequences share their first two cycles.
                case (i_step)
                    3'h0, 3'h3: o_cyc.addr = {3'h0, ua1};
                    3'h1, 3'h4: o_cyc.addr = {3'h0, ua2};
                    3'h2: o_cyc.addr = {(i_req.cmd == CMD_AS_ENTER) ? bk : 3'h0, ua1};
                    default: o_cyc.addr = {3'h0, ua1};
                endcase
                case (i_step)
                    3'h0: o_cyc.data = {8'h00, `FCD_D_UNL1};
                    3'h1: o_cyc.data = {8'h00, `FCD_D_UNL2};
                    3'h2: o_cyc.data = {8'h00, code3};
                    3'h3: o_cyc.data = {8'h00, `FCD_D_UNL1};
                    3'h4: o_cyc.data = {8'h00, `FCD_D_UNL2};
                    default: o_cyc.data = {8'h00, `FCD_D_CHIP};
                endcase
                o_cyc.last = (i_step == 3'h2) && (i_req.cmd == CMD_AS_ENTER
                    || i_req.cmd == CMD_SEC_ENTER || i_req.cmd == CMD_BYP_ENTER);
                if (i_step == 3'h3 && i_req.cmd == CMD_SEC_EXIT) begin
                    o_cyc.addr = 22'h000000;
                    o_cyc.data = {8'h00, `FCD_D_ZERO};
                    o_cyc.last = 1'b1;
                end
                if (i_step == 3'h3 && i_req.cmd == CMD_PROG) begin
                    o_cyc.addr = i_req.addr;
                    o_cyc.data = i_req.data;
                    o_cyc.last = 1'b1;
                end
                if (i_step == 3'h5) begin
                    o_cyc.last = 1'b1;
                    if (i_req.cmd == CMD_SECT_ERASE) begin
                        o_cyc.addr = {i_req.addr[21:`FCD_SECT_LSB], 12'h000};
                        o_cyc.data = {8'h00, `FCD_D_SECT};
                    end
                end
            end
        endcase
    end
endmodule : fcd_seq_rom

/* design/fcd_host.sv */
// Host-side driver for a banked asynchronous NOR flash command interface.
// Assumes the flash pins are wired straight to o_flash / i_dq_in and that
// the user waits for o_req_ready before each request.
`include "fcd_defines.svh"
`timescale 1ns/1ps
module fcd_host
    import fcd_pkg::*;
(
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_nrst,
    // User request port.
    input wire logic i_req_valid,
    input wire fcd_req_t i_req,
    input wire logic i_byte_mode,
    output logic o_req_ready,
    output logic o_done,
    output logic o_refused,
    output logic [15:0] o_rdata,
    output fcd_mode_t o_mode,
    // Flash pins.
    output fcd_pins_t o_flash,
    output logic o_byte_n,
    input wire logic [15:0] i_dq_in
);
    localparam fcd_pins_t PINS_IDLE = '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, rst_n: 1'b1,
        dq_oe_n: 1'b1, addr: 22'h000000, dq: 16'h0000};
    localparam fcd_state_t ST_RST = '{phase: PH_IDLE, mode: MD_READ, pins: PINS_IDLE, default: '0};

    fcd_state_t s_r, s_nxt;
    fcd_cyc_t cyc;
    logic [15:0] dq_sync;
    logic legal;
    logic fin;
    logic [2:0] req_bank;
    logic accept;

    // Read data come from the pins and must be synchronised first.
    fcd_sync #(
        .W(16)
    ) u_dq_sync (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_d(i_dq_in),
        .o_q(dq_sync)
    );

    fcd_seq_rom u_rom (
        .i_req(s_r.req),
        .i_byte(s_r.byte_m),
        .i_step(s_r.step),
        .o_cyc(cyc)
    );

    assign req_bank = i_req.addr[`FCD_BANK_MSB:`FCD_BANK_LSB];
    assign accept = (s_r.phase == PH_IDLE) && i_req_valid;

    // Requests the flash would ignore or misread are refused before any bus cycle.
    always_comb begin
        legal = 1'b0;
        case (i_req.cmd)
            CMD_READ: legal = 1'b1;
            CMD_RESET: legal = (s_r.mode != MD_ERASING) && (s_r.mode != MD_BYPASS);
            CMD_AS_ENTER: legal = (s_r.mode == MD_READ) || (s_r.mode == MD_SUSPENDED);
            CMD_AS_READ: legal = (s_r.mode == MD_AUTOSEL) && (req_bank == s_r.bank);
            CMD_SEC_ENTER: legal = (s_r.mode == MD_READ);
            CMD_SEC_EXIT: legal = (s_r.mode == MD_SECURE);
            CMD_PROG: legal = (s_r.mode == MD_READ) || (s_r.mode == MD_SECURE)
                || (s_r.mode == MD_SUSPENDED);
            CMD_BYP_ENTER: legal = (s_r.mode == MD_READ);
            CMD_BYP_PROG, CMD_BYP_EXIT: legal = (s_r.mode == MD_BYPASS);
            CMD_CHIP_ERASE, CMD_SECT_ERASE: legal = (s_r.mode == MD_READ);
            CMD_SUSPEND: legal = (s_r.mode == MD_ERASING) && s_r.sect && (req_bank == s_r.bank);
            CMD_RESUME: legal = (s_r.mode == MD_SUSPENDED) && (req_bank == s_r.bank);
            CMD_CFI: legal = (s_r.mode == MD_READ) || (s_r.mode == MD_AUTOSEL);
            CMD_ERASE_DONE: legal = (s_r.mode == MD_ERASING);
            CMD_HW_RESET: legal = 1'b1;
            default: legal = 1'b0;
        endcase
    end

    assign fin = cyc.last || (s_r.req.cmd == CMD_HW_RESET);

    // Bus cycle sequencer and bank mode tracker.
    always_comb begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        s_nxt.refused = 1'b0;
        case (s_r.phase)
            PH_IDLE: begin
                if (i_req_valid) begin
                    s_nxt.req = i_req;
                    s_nxt.byte_m = i_byte_mode;
                    s_nxt.step = 3'h0;
                    if (!legal) begin
                        s_nxt.refused = 1'b1;
                    end else if (i_req.cmd == CMD_ERASE_DONE) begin
                        s_nxt.mode = MD_READ;
                        s_nxt.susp = 1'b0;
                        s_nxt.done = 1'b1;
                    end else if (i_req.cmd == CMD_HW_RESET) begin
                        s_nxt.pins.rst_n = 1'b0;
                        s_nxt.cnt = 5'(`FCD_TRP_CYC - 1);
                        s_nxt.phase = PH_RSTP;
                    end else begin
                        s_nxt.phase = PH_START;
                    end
                end
            end
            PH_START: begin
                // Address settles a full cycle before the strobe falls.
                s_nxt.pins.addr = cyc.addr;
                s_nxt.pins.ce_n = 1'b0;
                if (cyc.rd) begin
                    s_nxt.pins.oe_n = 1'b0;
                    s_nxt.cnt = 5'(`FCD_TACC_CYC + `FCD_SYNC_CYC - 1);
                    s_nxt.phase = PH_RDWAIT;
                end else begin
                    s_nxt.pins.dq = cyc.data;
                    s_nxt.pins.dq_oe_n = 1'b0;
                    s_nxt.phase = PH_SETUP;
                end
            end
            PH_SETUP: begin
                s_nxt.pins.we_n = 1'b0;
                s_nxt.cnt = 5'(`FCD_TWP_CYC - 1);
                s_nxt.phase = PH_STROBE;
            end
            PH_STROBE: begin
                if (s_r.cnt == 5'h00) begin
                    s_nxt.pins.we_n = 1'b1;
                    s_nxt.phase = PH_HOLD;
                end else begin
                    s_nxt.cnt = s_r.cnt - 5'h01;
                end
            end
            PH_HOLD: begin
                // Data stay driven one cycle past the rising strobe.
                s_nxt.pins.ce_n = 1'b1;
                s_nxt.pins.dq_oe_n = 1'b1;
                s_nxt.cnt = 5'(`FCD_TWPH_CYC - 1);
                s_nxt.phase = PH_RECOV;
            end
            PH_RDWAIT: begin
                if (s_r.cnt == 5'h00) begin
                    s_nxt.rdata = dq_sync;
                    s_nxt.pins.oe_n = 1'b1;
                    s_nxt.pins.ce_n = 1'b1;
                    s_nxt.cnt = 5'(`FCD_TWPH_CYC - 1);
                    s_nxt.phase = PH_RECOV;
                end else begin
                    s_nxt.cnt = s_r.cnt - 5'h01;
                end
            end
            PH_RSTP: begin
                if (s_r.cnt == 5'h00) begin
                    s_nxt.pins.rst_n = 1'b1;
                    s_nxt.cnt = 5'(`FCD_TWPH_CYC - 1);
                    s_nxt.phase = PH_RECOV;
                end else begin
                    s_nxt.cnt = s_r.cnt - 5'h01;
                end
            end
            PH_RECOV: begin
                if (s_r.cnt != 5'h00) begin
                    s_nxt.cnt = s_r.cnt - 5'h01;
                end else if (!fin) begin
                    s_nxt.step = s_r.step + 3'h1;
                    s_nxt.phase = PH_START;
                end else begin
                    s_nxt.done = 1'b1;
                    s_nxt.phase = PH_IDLE;
                    case (s_r.req.cmd)
                        CMD_AS_ENTER: begin
                            s_nxt.mode = MD_AUTOSEL;
                            s_nxt.susp = (s_r.mode == MD_SUSPENDED);
                            s_nxt.bank = s_r.req.addr[`FCD_BANK_MSB:`FCD_BANK_LSB];
                        end
                        CMD_RESET: begin
                            if (s_r.mode == MD_AUTOSEL || s_r.mode == MD_CFI) begin
                                s_nxt.mode = s_r.susp ? MD_SUSPENDED : MD_READ;
                            end
                        end
                        CMD_SEC_ENTER: s_nxt.mode = MD_SECURE;
                        CMD_SEC_EXIT, CMD_BYP_EXIT: s_nxt.mode = MD_READ;
                        CMD_BYP_ENTER: s_nxt.mode = MD_BYPASS;
                        CMD_CHIP_ERASE, CMD_SECT_ERASE: begin
                            s_nxt.mode = MD_ERASING;
                            s_nxt.sect = (s_r.req.cmd == CMD_SECT_ERASE);
                            s_nxt.bank = s_r.req.addr[`FCD_BANK_MSB:`FCD_BANK_LSB];
                        end
                        CMD_SUSPEND: begin
                            s_nxt.mode = MD_SUSPENDED;
                            s_nxt.susp = 1'b1;
                        end
                        CMD_RESUME: begin
                            s_nxt.mode = MD_ERASING;
                            s_nxt.susp = 1'b0;
                        end
                        CMD_CFI: s_nxt.mode = MD_CFI;
                        CMD_HW_RESET: begin
                            s_nxt.mode = MD_READ;
                            s_nxt.susp = 1'b0;
                        end
                        default: s_nxt.mode = s_r.mode;
                    endcase
                end
            end
            default: s_nxt.phase = PH_IDLE;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            s_r <= ST_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs; ready and o_byte_n are the only combinational ones.
    assign o_req_ready = (s_r.phase == PH_IDLE);
    assign o_done = s_r.done;
    assign o_refused = s_r.refused;
    assign o_rdata = s_r.rdata;
    assign o_mode = s_r.mode;
    assign o_flash = s_r.pins;
    assign o_byte_n = ~s_r.byte_m;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    we_pulse_a: assert property ($fell(o_flash.we_n) |=> !o_flash.we_n ##1 o_flash.we_n)
        else $error("Write strobe low time wrong.");
    addr_stable_a: assert property (!o_flash.we_n |-> $stable(o_flash.addr) && !o_flash.ce_n)
        else $error("Address moved during write strobe.");
    data_hold_a: assert property ($rose(o_flash.we_n) |-> !o_flash.dq_oe_n && $stable(o_flash.dq))
        else $error("Data not held at strobe rise.");
    no_clash_a: assert property (!(!o_flash.oe_n && !o_flash.dq_oe_n))
        else $error("Host drives data during a read.");
    upper_byte_a: assert property (!o_flash.we_n && s_r.req.cmd != CMD_PROG
        && s_r.req.cmd != CMD_BYP_PROG |-> o_flash.dq[15:8] == 8'h00)
        else $error("Upper data byte set on a command.");
    bypass_gate_a: assert property (accept && i_req.cmd == CMD_BYP_PROG
        && s_r.mode != MD_BYPASS |=> o_refused && o_req_ready)
        else $error("Bypass program taken outside bypass.");
    bank_hold_a: assert property (accept && i_req.cmd == CMD_AS_READ && req_bank != s_r.bank
        |=> o_refused)
        else $error("Autoselect read at another bank taken.");
    erase_busy_a: assert property (accept && s_r.mode == MD_ERASING
        && i_req.cmd != CMD_SUSPEND && i_req.cmd != CMD_READ && i_req.cmd != CMD_HW_RESET
        && i_req.cmd != CMD_ERASE_DONE |=> o_refused)
        else $error("Command taken while erasing.");
    reset_pulse_a: assert property ($fell(o_flash.rst_n) |-> !o_flash.rst_n [*8])
        else $error("Hardware reset pulse too short.");
    unlock_a: assert property (!o_flash.we_n && s_r.req.cmd == CMD_AS_ENTER && s_r.step == 3'h0
        |-> o_flash.dq[7:0] == `FCD_D_UNL1 && o_flash.addr[18:0] == (s_r.byte_m ? `FCD_A_AAA : `FCD_A_555))
        else $error("First unlock cycle wrong.");
    reset_code_a: assert property (!o_flash.we_n && s_r.req.cmd == CMD_RESET
        |-> o_flash.dq[7:0] == `FCD_D_RESET)
        else $error("Reset command data wrong.");
    cfi_gate_a: assert property (accept && i_req.cmd == CMD_CFI
        && s_r.mode != MD_READ && s_r.mode != MD_AUTOSEL |=> o_refused)
        else $error("Query entry taken from a wrong mode.");
endmodule : fcd_host

/* dv/fcd_flash_model.sv */
// Behavioural flash device for the host driver bench.
// Assumes pins driven by fcd_host; byte-mode decoding follows its byte pin.
`timescale 1ns/1ps
module fcd_flash_model
    import fcd_pkg::*;
#(
    parameter logic [15:0] MFR = 16'h00a5, // Arbitrary maker code.
    parameter logic [15:0] DEV = 16'h005c // Arbitrary device code.
) (
    // Pins.
    input wire fcd_pins_t i_pins,
    input wire logic i_byte_n,
    output logic [15:0] o_dq
);
    logic [21:0] a = 22'h0;
    logic [1:0] st = 2'h0;
    logic as = 1'b0;
    logic [15:0] val;
    logic [15:0] held = 16'h0;
    wire ws = i_pins.we_n | i_pins.ce_n;
    wire rd = i_pins.ce_n | i_pins.oe_n;
    // Word mode ignores A11 and up; byte mode unlocks at AAA and 555 and doubles offsets.
    wire [11:0] am = i_byte_n ? {1'b0, a[10:0]} : a[11:0];
    wire [11:0] u1 = i_byte_n ? 12'h555 : 12'haaa;
    wire [11:0] u2 = i_byte_n ? 12'h2aa : 12'h555;
    wire [7:0] off = i_byte_n ? i_pins.addr[7:0] : {1'b0, i_pins.addr[7:1]};
    // Address at the later falling strobe, data at the first rising one.
    always @(negedge ws) a = i_pins.addr;
    always @(posedge ws) begin
        if (i_pins.dq[7:0] == 8'hf0) begin
            st = 2'h0;
            as = 1'b0;
        end else if (st == 2'h0 && am == u1 && i_pins.dq[7:0] == 8'haa) st = 2'h1;
        else if (st == 2'h1 && am == u2 && i_pins.dq[7:0] == 8'h55) st = 2'h2;
        else begin
            if (st == 2'h2 && i_pins.dq[7:0] == 8'h90) as = 1'b1;
            st = 2'h0;
        end
    end
    // Array reads return an address pattern; autoselect returns the codes.
    always @* begin
        if (!as) val = {2'h0, i_pins.addr[13:0]} ^ 16'h3c00;
        else if (off == 8'h00) val = MFR;
        else if (off == 8'h01) val = DEV;
        else if (off == 8'h03) val = 16'h0080;
        else if (off == 8'h02) val = {15'h0, i_pins.addr[12]}; // Sectors with A12 set count as protected.
        else val = 16'h0;
    end
    // A released bus shows the inverse of its last value, never a stale match.
    always @(posedge rd) held = val;
    assign o_dq = rd ? ~held : val;
endmodule : fcd_flash_model

/* dv/flash_command_decoder_test.sv */
// Self-checking bench for fcd_host against the flash model.
// Assumes the model decodes byte mode from the host's byte pin.
`timescale 1ns/1ps
module flash_command_decoder_test;
    import fcd_pkg::*;
    localparam logic [15:0] MFR = 16'h00a5; // Arbitrary.
    localparam logic [15:0] DEV = 16'h005c; // Arbitrary.
    logic i_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic req_valid = 1'b0;
    logic byte_m = 1'b0;
    logic byte_n;
    fcd_req_t req = '0;
    logic o_req_ready, o_done, o_refused;
    logic [15:0] o_rdata, dq;
    fcd_mode_t o_mode;
    fcd_pins_t pins;
    int failures = 0;
    int samples_checked = 0;
    fcd_host i_dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_req_valid(req_valid), .i_req(req), .i_byte_mode(byte_m),
        .o_req_ready(o_req_ready), .o_done(o_done), .o_refused(o_refused), .o_rdata(o_rdata), .o_mode(o_mode),
        .o_flash(pins), .o_byte_n(byte_n), .i_dq_in(dq));
    fcd_flash_model #(.MFR(MFR), .DEV(DEV)) i_flash (.i_pins(pins), .i_byte_n(byte_n), .o_dq(dq));
    // Clock at 50 MHz.
    initial begin
        forever #10 i_clk = ~i_clk;
    end
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : final_report
    // One request: take, bounded wait for the answer, then flag and mode.
    task automatic run(input fcd_cmd_t c, input logic [21:0] ad, input fcd_as_t s, input logic rf,
                       input fcd_mode_t md);
        int n;
        n = 0;
        @(negedge i_clk);
        req_valid = 1'b1;
        req = '{cmd: c, sel: s, addr: ad, data: 16'h0};
        @(negedge i_clk);
        req_valid = 1'b0;
        while (o_done !== 1'b1 && o_refused !== 1'b1 && n < 200) begin
            @(negedge i_clk);
            n++;
        end
        // A hang leaves both pulses low and so counts as a mismatch.
        check({14'h0, o_done, o_refused}, {14'h0, !rf, rf});
        @(negedge i_clk);
        check({12'h0, o_req_ready, o_mode}, {12'h0, 1'b1, md});
    endtask : run
    // The run is a few hundred cycles; this limit is far beyond it.
    initial begin
        #200000;
        failures++;
        final_report();
    end
    // Plain reads, then word-mode autoselect codes, query entry and reset.
    task automatic test_autoselect;
        run(CMD_READ, 22'h01234, AS_MFR, 1'b0, MD_READ);
        check(o_rdata, 16'h1234 ^ 16'h3c00);
        run(CMD_AS_READ, 22'h080000, AS_MFR, 1'b1, MD_READ);
        run(CMD_AS_ENTER, 22'h080000, AS_MFR, 1'b0, MD_AUTOSEL);
        run(CMD_AS_READ, 22'h080000, AS_MFR, 1'b0, MD_AUTOSEL);
        check(o_rdata, MFR);
        run(CMD_AS_READ, 22'h080000, AS_DEV1, 1'b0, MD_AUTOSEL);
        check(o_rdata, DEV);
        run(CMD_AS_READ, 22'h080000, AS_LOCK, 1'b0, MD_AUTOSEL);
        check(o_rdata, 16'h0080);
        run(CMD_AS_READ, 22'h081000, AS_PROT, 1'b0, MD_AUTOSEL);
        check(o_rdata, 16'h0001);
        run(CMD_AS_READ, 22'h080000, AS_PROT, 1'b0, MD_AUTOSEL);
        check(o_rdata, 16'h0000);
        run(CMD_AS_READ, 22'h100000, AS_MFR, 1'b1, MD_AUTOSEL);
        run(CMD_CFI, 22'h0, AS_MFR, 1'b0, MD_CFI);
        run(CMD_RESET, 22'h0, AS_MFR, 1'b0, MD_READ);
        run(CMD_READ, 22'h00077, AS_MFR, 1'b0, MD_READ);
        check(o_rdata, 16'h0077 ^ 16'h3c00);
    endtask : test_autoselect
    // Byte-mode addressing: unlock addresses and autoselect offsets move.
    task automatic test_byte_mode;
        byte_m = 1'b1;
        run(CMD_AS_ENTER, 22'h080000, AS_MFR, 1'b0, MD_AUTOSEL);
        run(CMD_AS_READ, 22'h080000, AS_DEV1, 1'b0, MD_AUTOSEL);
        check(o_rdata, DEV);
        run(CMD_AS_READ, 22'h080000, AS_LOCK, 1'b0, MD_AUTOSEL);
        check(o_rdata, 16'h0080);
        run(CMD_RESET, 22'h0, AS_MFR, 1'b0, MD_READ);
        byte_m = 1'b0;
    endtask : test_byte_mode
    // Unlock-bypass entry, program and exit; query entry is refused there.
    task automatic test_bypass;
        run(CMD_BYP_PROG, 22'h0, AS_MFR, 1'b1, MD_READ);
        run(CMD_BYP_ENTER, 22'h0, AS_MFR, 1'b0, MD_BYPASS);
        run(CMD_CFI, 22'h0, AS_MFR, 1'b1, MD_BYPASS);
        run(CMD_BYP_PROG, 22'h00100, AS_MFR, 1'b0, MD_BYPASS);
        run(CMD_BYP_EXIT, 22'h0, AS_MFR, 1'b0, MD_READ);
    endtask : test_bypass
    // Sector and chip erase with suspend, resume and the commands refused meanwhile.
    task automatic test_erase;
        run(CMD_SUSPEND, 22'h080000, AS_MFR, 1'b1, MD_READ);
        run(CMD_SECT_ERASE, 22'h083000, AS_MFR, 1'b0, MD_ERASING);
        run(CMD_RESET, 22'h0, AS_MFR, 1'b1, MD_ERASING);
        run(CMD_SUSPEND, 22'h080000, AS_MFR, 1'b0, MD_SUSPENDED);
        run(CMD_RESUME, 22'h100000, AS_MFR, 1'b1, MD_SUSPENDED);
        run(CMD_AS_ENTER, 22'h080000, AS_MFR, 1'b0, MD_AUTOSEL);
        run(CMD_RESET, 22'h0, AS_MFR, 1'b0, MD_SUSPENDED);
        run(CMD_RESUME, 22'h080000, AS_MFR, 1'b0, MD_ERASING);
        run(CMD_ERASE_DONE, 22'h0, AS_MFR, 1'b0, MD_READ);
        run(CMD_CHIP_ERASE, 22'h0, AS_MFR, 1'b0, MD_ERASING);
        run(CMD_SUSPEND, 22'h0, AS_MFR, 1'b1, MD_ERASING);
        run(CMD_HW_RESET, 22'h0, AS_MFR, 1'b0, MD_READ);
    endtask : test_erase
    // Secure-region entry and exit, then a full program sequence.
    task automatic test_secure_program;
        run(CMD_SEC_ENTER, 22'h0, AS_MFR, 1'b0, MD_SECURE);
        run(CMD_SEC_EXIT, 22'h0, AS_MFR, 1'b0, MD_READ);
        run(CMD_PROG, 22'h00200, AS_MFR, 1'b0, MD_READ);
    endtask : test_secure_program
    initial begin
        repeat (3) @(negedge i_clk);
        i_nrst = 1'b1;
        test_autoselect();
        test_byte_mode();
        test_bypass();
        test_erase();
        test_secure_program();
        final_report();
    end
endmodule : flash_command_decoder_test
